// ==== mpi_access.sv ====
// Process-image and script-array access engine
`timescale 1ns/100ps
// Functional notes
// - PC bit 0 set while a data set spans messages, clear otherwise
// - PC bit 1 selects one-byte (0) or two-byte (1) control field
// - PC bit 2 set means a counter byte is present
// - PC bit 7: 0 reads the object, 1 writes it
// - Extended failure: FC+80, FF, MEI 0D, code CE, 4-byte error
// - Unsupported option: extended code AE plus supported options
// - Standard exceptions 01 function, 02 address, 03 value, 04 fail (04 is never raised here)
// - Separate 16-entry rx and tx map tables, subindex 0 counts
// - Map tables written by the extended command 2B
// - Mapped values packed back to back, in entry order
// - Dummy indices 0002..0007 always transfer zero
// - Rx image at register 6000, tx image at 5000
// - Images served by FC 03, 04, 06, 10 and combined 17
// - Script output array read-only from register 2000
// - Script input array write-only from register 3000
// - Script windows served by FC 03, 04, 10 and 17 only
module mpi_access
	import mpi_pkg::*;
(
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_B,
	input  wire logic        I_REQ_VALID,
	output logic             O_REQ_READY,
	input  wire logic [7:0]  I_REQ_FC,
	input  wire logic [15:0] I_REQ_RADDR,
	input  wire logic [15:0] I_REQ_RQTY,
	input  wire logic [15:0] I_REQ_WADDR,
	input  wire logic [15:0] I_REQ_WQTY,
	input  wire logic        I_WR_VALID,
	output logic             O_WR_READY,
	input  wire logic [15:0] I_WR_DATA,
	output logic             O_RD_VALID,
	input  wire logic        I_RD_READY,
	output logic      [15:0] O_RD_DATA,
	output logic             O_RSP_DONE,
	output logic             O_RSP_EXC,
	output logic      [7:0]  O_RSP_CODE,
	input  wire logic        I_EXT_VALID,
	output logic             O_EXT_READY,
	input  wire logic [15:0] I_EXT_PC,
	input  wire logic        I_EXT_TX_SEL,
	input  wire logic [7:0]  I_EXT_SUB,
	input  wire logic [31:0] I_EXT_WDATA,
	output logic             O_EXT_DONE,
	output logic             O_EXT_FAIL,
	output logic      [7:0]  O_EXT_FC,
	output logic      [7:0]  O_EXT_MB_EXC,
	output logic      [7:0]  O_EXT_MEI,
	output logic      [7:0]  O_EXT_CODE,
	output logic      [31:0] O_EXT_ERR,
	output logic      [31:0] O_EXT_RDATA,
	output logic             O_PC_MULTI,
	output logic             O_PC_WIDE,
	output logic             O_PC_COUNTER,
	output logic             O_PC_WRITE,
	output logic             O_OD_RD,
	output logic             O_OD_WE,
	output logic      [15:0] O_OD_INDEX,
	output logic      [7:0]  O_OD_SUB,
	output logic      [31:0] O_OD_WDATA,
	input  wire logic [31:0] I_OD_RDATA,
	input  wire logic        I_SOUT_WE,
	input  wire logic [4:0]  I_SOUT_IDX,
	input  wire logic [31:0] I_SOUT_DATA,
	input  wire logic [4:0]  I_SIN_IDX,
	output logic      [31:0] O_SIN_DATA
);
	mpi_state_type state_ff;
	logic [7:0]  fc_ff;
	logic [7:0]  exc_ff;
	logic [15:0] raddr_ff;
	logic [15:0] rqty_ff;
	logic [15:0] waddr_ff;
	logic [15:0] wqty_ff;
	logic        has_rd_ff;
	logic [6:0]  cnt_ff;
	logic [6:0]  ptr_ff;
	logic [31:0] rx_map_ff [MAP_ENTRIES];
	logic [31:0] tx_map_ff [MAP_ENTRIES];
	logic [4:0]  rx_cnt_ff;
	logic [4:0]  tx_cnt_ff;
	logic [7:0]  rx_img_ff [IMG_BYTES];
	logic [7:0]  tx_img_ff [IMG_BYTES];
	logic [31:0] sin_ff [SCRIPT_WORDS];
	logic [31:0] sout_ff [SCRIPT_WORDS];
	logic [10:0] rx_bits;
	logic [10:0] tx_bits;
	logic [6:0]  rx_words;
	logic [6:0]  tx_words;
	logic        req_take;
	logic        has_rd;
	logic        has_wr;
	logic        fc_ok;
	logic [15:0] wq;
	logic [7:0]  wr_exc;
	logic [7:0]  rd_exc;
	logic [7:0]  req_exc;
	logic        wr_rx;
	logic        rd_tx;
	logic [6:0]  woff;
	logic [6:0]  roff;
	logic        wr_last;
	logic        rd_last;
	mpi_state_type rd_next;
	logic [31:0] ent;
	logic [2:0]  ent_bytes;
	logic        ent_dummy;
	logic        ent_live;
	logic [31:0] unpack_val;
	logic [31:0] pack_val;
	logic [15:0] send_word;
	logic        fifo_ready;
	logic        ext_take;
	logic        pc_multi;
	logic        pc_wide;
	logic        pc_counter;
	logic        pc_write;
	logic        pc_unsup;
	logic [4:0]  sel_cnt;
	logic [3:0]  ent_idx;

	function automatic logic in_win(input logic [15:0] a,
		input logic [15:0] q, input logic [15:0] b, input logic [6:0] n);
		in_win = (a >= b) && ({1'b0, a} + {1'b0, q} <= {1'b0, b} + 17'(n));
	endfunction : in_win

	function automatic logic [7:0] win_check(input logic [15:0] a,
		input logic [15:0] q, input logic wr, input logic single,
		input logic [6:0] rxw, input logic [6:0] txw);
		logic [7:0] r;
		r = EXC_ILL_ADDR;
		if (q == 16'h0000)
			r = EXC_ILL_VALUE;
		else if (in_win(a, q, ADDR_SCRIPT_OUT, SCRIPT_REGS) ||
			in_win(a, q, ADDR_SCRIPT_IN, SCRIPT_REGS)) begin
			if (single)
				r = EXC_ILL_FUNC;
			else if (wr == (a < ADDR_SCRIPT_IN))
				r = EXC_ILL_ADDR;
			else if (a[0])
				r = EXC_ILL_ADDR;
			else if (q[0])
				r = EXC_ILL_VALUE;
			else
				r = EXC_NONE;
		end else if (in_win(a, q, ADDR_TX_IMAGE, txw))
			r = wr ? EXC_ILL_ADDR : EXC_NONE;
		else if (in_win(a, q, ADDR_RX_IMAGE, rxw))
			r = wr ? EXC_NONE : EXC_ILL_ADDR;
		return r;
	endfunction : win_check

	// Image sizes follow the live entry counts
	always_comb begin
		rx_bits = '0;
		tx_bits = '0;
		for (int i = 0; i < MAP_ENTRIES; i++) begin
			if (5'(i) < rx_cnt_ff)
				rx_bits = rx_bits + 11'(rx_map_ff[i][7:0]);
			if (5'(i) < tx_cnt_ff)
				tx_bits = tx_bits + 11'(tx_map_ff[i][7:0]);
		end
	end
	assign rx_words = 7'((rx_bits + 11'd15) >> 4);
	assign tx_words = 7'((tx_bits + 11'd15) >> 4);

	assign O_REQ_READY = state_ff == ST_IDLE;
	assign req_take = I_REQ_VALID && O_REQ_READY;
	assign has_rd = I_REQ_FC == FC_RD_HOLD || I_REQ_FC == FC_RD_INPUT ||
		I_REQ_FC == FC_RD_WR;
	assign has_wr = I_REQ_FC == FC_WR_SINGLE || I_REQ_FC == FC_WR_MULTI ||
		I_REQ_FC == FC_RD_WR;
	assign fc_ok = has_rd || has_wr;
	assign wq = (I_REQ_FC == FC_WR_SINGLE) ? 16'h0001 : I_REQ_WQTY;
	assign wr_exc = win_check(I_REQ_WADDR, wq, 1'b1,
		I_REQ_FC == FC_WR_SINGLE, rx_words, tx_words);
	assign rd_exc = win_check(I_REQ_RADDR, I_REQ_RQTY, 1'b0, 1'b0,
		rx_words, tx_words);
	always_comb begin
		if (!fc_ok)
			req_exc = EXC_ILL_FUNC;
		else if (has_wr && wr_exc != EXC_NONE)
			req_exc = wr_exc;
		else if (has_rd && rd_exc != EXC_NONE)
			req_exc = rd_exc;
		else
			req_exc = EXC_NONE;
	end

	assign wr_rx = waddr_ff >= ADDR_RX_IMAGE;
	assign rd_tx = raddr_ff >= ADDR_TX_IMAGE;
	assign woff = 7'(waddr_ff - (wr_rx ? ADDR_RX_IMAGE : ADDR_SCRIPT_IN))
		+ cnt_ff;
	assign roff = 7'(raddr_ff - (rd_tx ? ADDR_TX_IMAGE : ADDR_SCRIPT_OUT))
		+ cnt_ff;
	assign wr_last = {9'd0, cnt_ff} + 16'd1 == wqty_ff;
	assign rd_last = {9'd0, cnt_ff} + 16'd1 == rqty_ff;
	assign rd_next = !has_rd_ff ? ST_FINISH : (rd_tx ? ST_PACK : ST_SEND);

	// Current map entry for the unpack or pack walk
	assign ent_idx   = cnt_ff[3:0];
	assign ent       = (state_ff == ST_UNPACK) ? rx_map_ff[ent_idx]
		: tx_map_ff[ent_idx];
	assign ent_bytes = ent[5:3];
	assign ent_dummy = ent[31:16] >= DUMMY_FIRST &&
		ent[31:16] <= DUMMY_LAST;
	assign ent_live  = (state_ff == ST_UNPACK) ? cnt_ff < {2'b00, rx_cnt_ff}
		: cnt_ff < {2'b00, tx_cnt_ff};
	assign O_OD_INDEX = ent[31:16];
	assign O_OD_SUB   = ent[15:8];
	assign O_OD_WE    = state_ff == ST_UNPACK && ent_live && !ent_dummy;
	assign O_OD_RD    = state_ff == ST_PACK && ent_live && !ent_dummy;
	assign O_OD_WDATA = unpack_val;
	assign pack_val   = ent_dummy ? 32'h00000000 : I_OD_RDATA;

	// Values are big-endian inside the image
	always_comb begin
		unpack_val = '0;
		for (int k = 0; k < 4; k++)
			if (3'(k) < ent_bytes)
				unpack_val = {unpack_val[23:0],
					rx_img_ff[6'(ptr_ff + 7'(k))]};
	end

	assign send_word = rd_tx ? {tx_img_ff[6'({roff, 1'b0})],
		tx_img_ff[6'({roff, 1'b1})]}
		: (roff[0] ? sout_ff[roff[5:1]][15:0] : sout_ff[roff[5:1]][31:16]);
	assign O_WR_READY = state_ff == ST_WRGET;

	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_ff  <= ST_IDLE;
			fc_ff     <= '0;
			exc_ff    <= EXC_NONE;
			raddr_ff  <= '0;
			rqty_ff   <= '0;
			waddr_ff  <= '0;
			wqty_ff   <= '0;
			has_rd_ff <= 1'b0;
			cnt_ff    <= '0;
			ptr_ff    <= '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					cnt_ff <= '0;
					ptr_ff <= '0;
					if (req_take) begin
						fc_ff     <= I_REQ_FC;
						exc_ff    <= req_exc;
						raddr_ff  <= I_REQ_RADDR;
						rqty_ff   <= I_REQ_RQTY;
						waddr_ff  <= I_REQ_WADDR;
						wqty_ff   <= wq;
						has_rd_ff <= has_rd;
						if (req_exc != EXC_NONE)
							state_ff <= ST_FINISH;
						else if (has_wr)
							state_ff <= ST_WRGET;
						else if (I_REQ_RADDR >= ADDR_TX_IMAGE)
							state_ff <= ST_PACK;
						else
							state_ff <= ST_SEND;
					end
				end
				ST_WRGET: begin
					if (I_WR_VALID) begin
						cnt_ff <= wr_last ? '0 : cnt_ff + 1'b1;
						if (wr_last)
							state_ff <= wr_rx ? ST_UNPACK : rd_next;
					end
				end
				ST_UNPACK: begin
					if (ent_live) begin
						cnt_ff <= cnt_ff + 1'b1;
						ptr_ff <= ptr_ff + {4'd0, ent_bytes};
					end else begin
						cnt_ff   <= '0;
						ptr_ff   <= '0;
						state_ff <= rd_next;
					end
				end
				ST_PACK: begin
					if (ent_live) begin
						cnt_ff <= cnt_ff + 1'b1;
						ptr_ff <= ptr_ff + {4'd0, ent_bytes};
					end else begin
						cnt_ff   <= '0;
						state_ff <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (fifo_ready) begin
						cnt_ff <= cnt_ff + 1'b1;
						if (rd_last)
							state_ff <= ST_FINISH;
					end
				end
				ST_FINISH: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	assign O_RSP_DONE = state_ff == ST_FINISH;
	assign O_RSP_EXC  = O_RSP_DONE && exc_ff != EXC_NONE;
	assign O_RSP_CODE = exc_ff;

	// Image buffers hold no reset; contents are only valid once mapped
	always_ff @(posedge I_CORE_CLK) begin
		if (state_ff == ST_WRGET && I_WR_VALID && wr_rx) begin
			rx_img_ff[6'({woff, 1'b0})] <= I_WR_DATA[15:8];
			rx_img_ff[6'({woff, 1'b1})] <= I_WR_DATA[7:0];
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (state_ff == ST_PACK && ent_live)
			for (int k = 0; k < 4; k++)
				if (3'(k) < ent_bytes)
					tx_img_ff[6'(ptr_ff + 7'(k))] <= 8'(pack_val >>
						((32'(ent_bytes) - 32'd1 - 32'(k)) * 8));
	end

	// Script arrays; first register of a pair carries the upper half
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int i = 0; i < SCRIPT_WORDS; i++) begin
				sin_ff[i]  <= '0;
				sout_ff[i] <= '0;
			end
			O_SIN_DATA <= '0;
		end else begin
			if (state_ff == ST_WRGET && I_WR_VALID && !wr_rx) begin
				if (woff[0])
					sin_ff[woff[5:1]][15:0] <= I_WR_DATA;
				else
					sin_ff[woff[5:1]][31:16] <= I_WR_DATA;
			end
			if (I_SOUT_WE)
				sout_ff[I_SOUT_IDX] <= I_SOUT_DATA;
			O_SIN_DATA <= sin_ff[I_SIN_IDX];
		end
	end

	mpi_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.i_clk       (I_CORE_CLK),
		.i_rst_b     (I_RST_B),
		.i_in_valid  (state_ff == ST_SEND),
		.o_in_ready  (fifo_ready),
		.i_in_data   (send_word),
		.o_out_valid (O_RD_VALID),
		.i_out_ready (I_RD_READY),
		.o_out_data  (O_RD_DATA)
	);

	mpi_pc_decode u_pc (
		.i_pc      (I_EXT_PC),
		.o_multi   (pc_multi),
		.o_wide    (pc_wide),
		.o_counter (pc_counter),
		.o_write   (pc_write),
		.o_unsup   (pc_unsup)
	);

	assign O_EXT_READY = state_ff == ST_IDLE && !I_REQ_VALID;
	assign ext_take = I_EXT_VALID && O_EXT_READY;
	assign sel_cnt  = I_EXT_TX_SEL ? tx_cnt_ff : rx_cnt_ff;
	assign O_EXT_MB_EXC = EXC_EXTENDED;
	assign O_EXT_MEI    = MEI_TYPE;
	assign O_EXT_FC     = O_EXT_FAIL ? (FC_EXT | FC_ERR_FLAG) : FC_EXT;

	// Extended command: decode, map table access, failure report
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int i = 0; i < MAP_ENTRIES; i++) begin
				rx_map_ff[i] <= '0;
				tx_map_ff[i] <= '0;
			end
			rx_cnt_ff    <= '0;
			tx_cnt_ff    <= '0;
			O_EXT_DONE   <= 1'b0;
			O_EXT_FAIL   <= 1'b0;
			O_EXT_CODE   <= '0;
			O_EXT_ERR    <= ERR_NONE;
			O_EXT_RDATA  <= '0;
			O_PC_MULTI   <= 1'b0;
			O_PC_WIDE    <= 1'b0;
			O_PC_COUNTER <= 1'b0;
			O_PC_WRITE   <= 1'b0;
		end else begin
			O_EXT_DONE <= ext_take;
			if (ext_take) begin
				O_PC_MULTI   <= pc_multi;
				O_PC_WIDE    <= pc_wide;
				O_PC_COUNTER <= pc_counter;
				O_PC_WRITE   <= pc_write;
				O_EXT_FAIL   <= 1'b0;
				O_EXT_CODE   <= EXC_NONE;
				O_EXT_ERR    <= ERR_NONE;
				O_EXT_RDATA  <= '0;
				if (pc_unsup) begin
					O_EXT_FAIL  <= 1'b1;
					O_EXT_CODE  <= EXT_EXC_OPTION;
					O_EXT_RDATA <= {16'h0000, PC_SUPPORTED};
				end else if (I_EXT_SUB > {3'd0, MAP_MAX} ||
					(pc_write && I_EXT_SUB == 8'h00 &&
					I_EXT_WDATA > {27'd0, MAP_MAX}) ||
					(pc_write && I_EXT_SUB != 8'h00 && sel_cnt != 5'd0) ||
					(pc_write && I_EXT_SUB != 8'h00 &&
					I_EXT_WDATA[7:0] != 8'd8 && I_EXT_WDATA[7:0] != 8'd16 &&
					I_EXT_WDATA[7:0] != 8'd32)) begin
					O_EXT_FAIL <= 1'b1;
					O_EXT_CODE <= EXT_EXC_FAIL;
					if (I_EXT_SUB > {3'd0, MAP_MAX} || sel_cnt != 5'd0)
						O_EXT_ERR <= ERR_ACCESS;
					else if (I_EXT_SUB == 8'h00)
						O_EXT_ERR <= ERR_RANGE;
					else
						O_EXT_ERR <= ERR_LEN;
				end else if (pc_write) begin
					if (I_EXT_SUB == 8'h00 && I_EXT_TX_SEL)
						tx_cnt_ff <= I_EXT_WDATA[4:0];
					else if (I_EXT_SUB == 8'h00)
						rx_cnt_ff <= I_EXT_WDATA[4:0];
					else if (I_EXT_TX_SEL)
						tx_map_ff[4'(I_EXT_SUB - 8'd1)] <= I_EXT_WDATA;
					else
						rx_map_ff[4'(I_EXT_SUB - 8'd1)] <= I_EXT_WDATA;
				end else if (I_EXT_SUB == 8'h00)
					O_EXT_RDATA <= {27'd0, sel_cnt};
				else if (I_EXT_TX_SEL)
					O_EXT_RDATA <= tx_map_ff[4'(I_EXT_SUB - 8'd1)];
				else
					O_EXT_RDATA <= rx_map_ff[4'(I_EXT_SUB - 8'd1)];
			end
		end
	end

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);

	sequence s_req(logic [7:0] f, logic [15:0] a, logic [15:0] q);
		req_take && I_REQ_FC == f && ((f == FC_RD_HOLD || f == FC_RD_INPUT)
			? (I_REQ_RADDR == a && I_REQ_RQTY == q)
			: (I_REQ_WADDR == a && wq == q));
	endsequence
	sequence s_fail(logic [7:0] c);
		O_RSP_DONE && O_RSP_EXC && O_RSP_CODE == c;
	endsequence

	property p_bad_fc;
		req_take && !fc_ok |=> s_fail(EXC_ILL_FUNC);
	endproperty
	a_bad_fc: assert property (p_bad_fc)
		else $error("unknown function not refused with 01");
	property p_sout_ro;
		s_req(FC_WR_MULTI, ADDR_SCRIPT_OUT, 16'd2) |=> s_fail(EXC_ILL_ADDR);
	endproperty
	a_sout_ro: assert property (p_sout_ro)
		else $error("write to script output window accepted");
	property p_sin_wo;
		s_req(FC_RD_HOLD, ADDR_SCRIPT_IN, 16'd2) |=> s_fail(EXC_ILL_ADDR);
	endproperty
	a_sin_wo: assert property (p_sin_wo)
		else $error("read of script input window accepted");
	property p_script_single;
		s_req(FC_WR_SINGLE, ADDR_SCRIPT_IN, 16'd1) |=> s_fail(EXC_ILL_FUNC);
	endproperty
	a_script_single: assert property (p_script_single)
		else $error("single write to script window accepted");
	property p_misalign;
		s_req(FC_RD_INPUT, ADDR_SCRIPT_OUT + 16'd1, 16'd2)
			|=> s_fail(EXC_ILL_ADDR);
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned script read accepted");
	property p_ext_option;
		ext_take && I_EXT_PC[5] |=> O_EXT_DONE && O_EXT_FAIL &&
			O_EXT_CODE == EXT_EXC_OPTION && O_EXT_RDATA[15:0] == PC_SUPPORTED;
	endproperty
	a_ext_option: assert property (p_ext_option)
		else $error("unsupported option not answered with AE");
	property p_ext_frame;
		O_EXT_DONE && O_EXT_FAIL |-> O_EXT_FC == 8'hab &&
			O_EXT_MB_EXC == 8'hff && O_EXT_MEI == 8'h0d;
	endproperty
	a_ext_frame: assert property (p_ext_frame)
		else $error("extended failure frame fields wrong");
	property p_dummy;
		state_ff == ST_PACK && ent_live && ent_dummy |-> !O_OD_RD &&
			pack_val == 32'h00000000;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("dummy entry read from object store");
	property p_gapless;
		state_ff == ST_PACK && ent_live |=>
			ptr_ff == $past(ptr_ff) + {4'd0, $past(ent_bytes)};
	endproperty
	a_gapless: assert property (p_gapless)
		else $error("image pointer not advanced by entry size");
	property p_map_locked;
		ext_take && !pc_unsup && pc_write && I_EXT_SUB == 8'h01 &&
			sel_cnt != 5'd0 |=> O_EXT_FAIL && O_EXT_ERR == ERR_ACCESS;
	endproperty
	a_map_locked: assert property (p_map_locked)
		else $error("entry written while mapping active");
endmodule : mpi_access

// ==== mpi_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module mpi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign o_in_ready  = cnt_ff != (AW+1)'(DEPTH);
	assign o_out_valid = cnt_ff != '0;
	assign o_out_data  = mem_ff[rd_ff];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push)
			mem_ff[wr_ff] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule : mpi_fifo

// ==== mpi_master.sv ====
// Master model issuing standard register requests
`timescale 1ns/100ps
module mpi_master (
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	input  wire logic        i_req_ready,
	input  wire logic        i_wr_ready,
	input  wire logic        i_rd_valid,
	input  wire logic [15:0] i_rd_data,
	input  wire logic        i_done,
	input  wire logic        i_exc,
	input  wire logic [7:0]  i_code,
	output logic             o_req_valid,
	output logic      [7:0]  o_fc,
	output logic      [15:0] o_ra,
	output logic      [15:0] o_rq,
	output logic      [15:0] o_wa,
	output logic      [15:0] o_wq,
	output logic             o_wr_valid,
	output logic      [15:0] o_wr_data,
	output logic             o_rd_ready
);
	logic [15:0] rd_q[$];
	logic [2:0]  tick;
	initial begin
		{o_req_valid, o_wr_valid, o_rd_ready, tick} = '0;
		{o_fc, o_ra, o_rq, o_wa, o_wq, o_wr_data} = '0;
	end
	// Slow mode stalls reads so the FIFO fills
	always @(posedge i_clk) begin
		tick <= tick + 3'h1;
		o_rd_ready <= !i_slow || tick[2];
		if (i_rd_valid && o_rd_ready)
			rd_q.push_back(i_rd_data);
	end
	task automatic req(input logic [7:0] fc, input logic [15:0] ra, rq,
			wa, wq, input logic [31:0] wd, output logic [8:0] rsp);
		int i;
		i = 0;
		rsp = '1;
		@(posedge i_clk);
		#1 {o_fc, o_ra, o_rq, o_wa, o_wq} = {fc, ra, rq, wa, wq};
		o_req_valid = 1'b1;
		do @(posedge i_clk); while (!i_req_ready);
		#1 o_req_valid = 1'b0;
		// Words stop once done shows; refused words are held and offered again
		repeat (60) begin
			o_wr_valid = (fc[4] || fc == 8'h06) && i < wq;
			o_wr_data = i[0] ? wd[15:0] : wd[31:16];
			@(posedge i_clk);
			if (o_wr_valid && i_wr_ready)
				i++;
			if (i_done) begin
				rsp = {i_exc, i_code};
				i = 99;
			end
			#1;
		end
		o_wr_valid = 1'b0;
	endtask : req
endmodule : mpi_master

// ==== mpi_pc_decode.sv ====
// Protocol-control field decoder for the extended object command
`timescale 1ns/100ps
module mpi_pc_decode
	import mpi_pkg::*;
(
	input  wire logic [15:0] i_pc,
	output logic             o_multi,
	output logic             o_wide,
	output logic             o_counter,
	output logic             o_write,
	output logic             o_unsup
);
	logic [15:0] present;

	assign o_multi   = i_pc[PC_MULTI_BIT];
	assign o_wide    = i_pc[PC_WIDE_BIT];
	assign o_counter = i_pc[PC_COUNTER_BIT];
	assign o_write   = i_pc[PC_ACCESS_BIT];
	// Upper byte only exists in the two-byte form
	assign present   = o_wide ? 16'hffff : PC_NARROW_MASK;
	assign o_unsup   = |(i_pc & present & ~PC_SUPPORTED);
endmodule : mpi_pc_decode

// ==== mpi_pkg.sv ====
// Constants and types for the process-image access engine
package mpi_pkg;
	localparam logic [7:0]  FC_RD_HOLD     = 8'h03;
	localparam logic [7:0]  FC_RD_INPUT    = 8'h04;
	localparam logic [7:0]  FC_WR_SINGLE   = 8'h06;
	localparam logic [7:0]  FC_WR_MULTI    = 8'h10;
	localparam logic [7:0]  FC_RD_WR       = 8'h17;
	localparam logic [7:0]  FC_EXT         = 8'h2b;
	localparam logic [7:0]  FC_ERR_FLAG    = 8'h80;
	localparam logic [7:0]  EXC_NONE       = 8'h00;
	localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
	localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
	localparam logic [7:0]  EXC_ILL_VALUE  = 8'h03;
	localparam logic [7:0]  EXC_DEV_FAIL   = 8'h04;
	localparam logic [7:0]  EXC_EXTENDED   = 8'hff;
	localparam logic [7:0]  MEI_TYPE       = 8'h0d;
	localparam logic [7:0]  EXT_EXC_FAIL   = 8'hce;
	localparam logic [7:0]  EXT_EXC_OPTION = 8'hae;
	localparam int          PC_MULTI_BIT   = 0;
	localparam int          PC_WIDE_BIT    = 1;
	localparam int          PC_COUNTER_BIT = 2;
	localparam int          PC_ACCESS_BIT  = 7;
	localparam logic [15:0] PC_SUPPORTED   = 16'h0087;
	localparam logic [15:0] PC_NARROW_MASK = 16'h00ff;
	localparam logic [15:0] ADDR_SCRIPT_OUT = 16'h07d0;
	localparam logic [15:0] ADDR_SCRIPT_IN  = 16'h0bb8;
	localparam logic [15:0] ADDR_TX_IMAGE   = 16'h1388;
	localparam logic [15:0] ADDR_RX_IMAGE   = 16'h1770;
	localparam int          SCRIPT_WORDS   = 32;
	localparam logic [6:0]  SCRIPT_REGS    = 7'h40;
	localparam int          MAP_ENTRIES    = 16;
	localparam logic [4:0]  MAP_MAX        = 5'h10;
	localparam int          IMG_BYTES      = 64;
	localparam logic [15:0] DUMMY_FIRST    = 16'h0002;
	localparam logic [15:0] DUMMY_LAST     = 16'h0007;
	localparam logic [31:0] ERR_NONE       = 32'h00000000;
	localparam logic [31:0] ERR_ACCESS     = 32'hffff0008;
	localparam logic [31:0] ERR_LEN        = 32'hffff0011;
	localparam logic [31:0] ERR_RANGE      = 32'hffff0015;
	localparam int          WORD_W         = 16;
	localparam int          FIFO_DEPTH     = 4;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_WRGET  = 6'h02,
		ST_UNPACK = 6'h04,
		ST_PACK   = 6'h08,
		ST_SEND   = 6'h10,
		ST_FINISH = 6'h20
	} mpi_state_type;
endpackage : mpi_pkg

// ==== testbench.sv ====
// Self-checking bench for the access engine
`timescale 1ns/100ps
module testbench;
	import mpi_pkg::*;
	logic I_CORE_CLK, I_RST_B, I_REQ_VALID, O_REQ_READY, I_WR_VALID;
	logic O_WR_READY, O_RD_VALID, I_RD_READY, O_RSP_DONE, O_RSP_EXC;
	logic I_EXT_VALID, O_EXT_READY, I_EXT_TX_SEL, O_EXT_DONE, O_EXT_FAIL;
	logic O_PC_MULTI, O_PC_WIDE, O_PC_COUNTER, O_PC_WRITE, O_OD_RD;
	logic O_OD_WE, I_SOUT_WE, slow;
	logic [4:0] I_SOUT_IDX, I_SIN_IDX;
	logic [7:0] I_REQ_FC, O_RSP_CODE, I_EXT_SUB, O_EXT_FC, O_EXT_MB_EXC;
	logic [7:0] O_EXT_MEI, O_EXT_CODE, O_OD_SUB;
	logic [15:0] I_REQ_RADDR, I_REQ_RQTY, I_REQ_WADDR, I_REQ_WQTY;
	logic [15:0] I_WR_DATA, O_RD_DATA, I_EXT_PC, O_OD_INDEX;
	logic [31:0] I_EXT_WDATA, O_EXT_ERR, O_EXT_RDATA, O_OD_WDATA;
	logic [31:0] I_OD_RDATA, I_SOUT_DATA, O_SIN_DATA, sout[2], od, wd;
	logic [8:0] rsp;
	int err_total = 0, tests_run = 0, seed, cyc = 0, od_n = 0, rd_n = 0;
	logic [15:0] opt[5] = '{16'h8, 16'h10, 16'h20, 16'h40, 16'h102};
	logic [47:0] bad[7] = '{48'h05_07d0_0002_01, 48'h04_07d1_0002_02,
		48'h10_0bb8_0001_03, 48'h10_07d0_0002_02, 48'h03_0bb8_0002_02,
		48'h06_0bb8_0001_01, 48'h03_1770_0001_02};
	mpi_access DUT (.*);
	mpi_master M (.i_clk(I_CORE_CLK), .i_slow(slow),
		.i_req_ready(O_REQ_READY), .i_wr_ready(O_WR_READY),
		.i_rd_valid(O_RD_VALID), .i_rd_data(O_RD_DATA),
		.i_done(O_RSP_DONE), .i_exc(O_RSP_EXC), .i_code(O_RSP_CODE),
		.o_req_valid(I_REQ_VALID), .o_fc(I_REQ_FC), .o_ra(I_REQ_RADDR),
		.o_rq(I_REQ_RQTY), .o_wa(I_REQ_WADDR), .o_wq(I_REQ_WQTY),
		.o_wr_valid(I_WR_VALID), .o_wr_data(I_WR_DATA),
		.o_rd_ready(I_RD_READY));
	task automatic stop_test;
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic ext(input logic [15:0] pc, input logic [7:0] sub,
			input logic [31:0] d);
		@(posedge I_CORE_CLK);
		#1 {I_EXT_PC, I_EXT_SUB, I_EXT_WDATA, I_EXT_VALID} = {pc, sub, d, 1'b1};
		do @(posedge I_CORE_CLK); while (!O_EXT_READY);
		#1 I_EXT_VALID = 1'b0;
		@(posedge I_CORE_CLK);
		chk("ext_done", 32'h1, O_EXT_DONE);
	endtask : ext
	initial begin
		I_CORE_CLK = 1'b0;
		forever #25 I_CORE_CLK = ~I_CORE_CLK;
	end
	// Whole run needs about 800 cycles
	always @(posedge I_CORE_CLK) begin
		cyc <= cyc + 1;
		if (O_OD_WE) begin
			od_n <= od_n + 1;
			od <= {O_OD_INDEX, O_OD_SUB, O_OD_WDATA[7:0]};
		end
		if (O_OD_RD)
			rd_n <= rd_n + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		seed = 76;
		{I_RST_B, I_EXT_VALID, I_EXT_TX_SEL, I_SOUT_WE, slow} = '0;
		{I_EXT_PC, I_EXT_SUB, I_EXT_WDATA, I_SOUT_IDX, I_SIN_IDX} = '0;
		{I_SOUT_DATA, I_OD_RDATA} = '0;
		repeat (8) @(posedge I_CORE_CLK);
		#1 I_RST_B = 1'b1;
		ext(16'h80, 8'h0, 32'h0);
		ext(16'h80, 8'h1, 32'h00050008);
		ext(16'h80, 8'h2, 32'h60410108);
		ext(16'h87, 8'h0, 32'h2);
		chk("pc", 32'hf, {O_PC_MULTI, O_PC_WIDE,
			O_PC_COUNTER, O_PC_WRITE});
		ext(16'h0, 8'h1, 32'h0);
		chk("map", 32'h00050008, O_EXT_RDATA);
		ext(16'h80, 8'h1, 32'h1);
		chk("ce", 32'habff0dce,
			{O_EXT_FC, O_EXT_MB_EXC, O_EXT_MEI, O_EXT_CODE});
		chk("ce_err", 32'hffff0008, O_EXT_ERR);
		foreach (opt[k]) begin
			ext(opt[k], 8'h0, 32'h0);
			chk("ae", 32'habae0087,
				{O_EXT_FC, O_EXT_CODE, O_EXT_RDATA[15:0]});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge I_CORE_CLK);
			sout[k] = $random(seed);
			#1 {I_SOUT_WE, I_SOUT_IDX, I_SOUT_DATA} = {1'b1, 5'(k), sout[k]};
		end
		@(posedge I_CORE_CLK);
		#1 {I_SOUT_WE, slow} = 2'b01;
		M.req(8'h03, 16'h7d0, 16'h4, 16'h0, 16'h0, 32'h0, rsp);
		chk("rd_n", {23'h0, rsp} + 32'h4, M.rd_q.size());
		for (int k = 0; k < 2; k++)
			chk("rd", sout[k], {M.rd_q[2*k], M.rd_q[2*k+1]});
		M.rd_q.delete();
		wd = $random(seed);
		M.req(8'h17, 16'h7d2, 16'h2,
			16'hbba, 16'h2, wd, rsp);
		chk("rsp17", 32'h0, rsp);
		I_SIN_IDX = 5'h1;
		repeat (2) @(posedge I_CORE_CLK);
		#1 chk("sin", wd, O_SIN_DATA);
		chk("rd17", sout[1], {M.rd_q[0], M.rd_q[1]});
		M.rd_q.delete();
		for (int k = 1; k < 3; k++) begin
			wd = {8'h5a, 8'($random(seed)), 16'h0};
			M.req(k[0] ? 8'h10 : 8'h06, 16'h0, 16'h0,
				16'h1770, 16'h1, wd, rsp);
			chk("od_n", k + rsp, od_n);
			chk("od", {16'h6041, 8'h01, wd[23:16]}, od);
		end
		I_EXT_TX_SEL = 1'b1;
		ext(16'h80, 8'h0, 32'h0);
		ext(16'h80, 8'h1, 32'h60410010);
		ext(16'h80, 8'h2, 32'h00050008);
		ext(16'h80, 8'h3, 32'h60610008);
		ext(16'h80, 8'h0, 32'h3);
		wd = $random(seed);
		#1 I_OD_RDATA = wd;
		M.req(8'h04, 16'h1388, 16'h2, 16'h0, 16'h0, 32'h0, rsp);
		chk("od_rd", {23'h0, rsp} + 32'h2, rd_n);
		chk("tx", {wd[15:0], 8'h0, wd[7:0]},
			{M.rd_q[0], M.rd_q[1]});
		foreach (bad[k]) begin
			M.req(bad[k][47:40], bad[k][39:24], bad[k][23:8], bad[k][39:24],
				bad[k][23:8], 32'h0, rsp);
			chk("exc", {1'b1, bad[k][7:0]}, rsp);
		end
		stop_test();
	end
endmodule : testbench
